// file: design/bms_map.svh
// Address map, field positions, codes and timing constants of the buck mode block
`ifndef BMS_MAP_SVH
`define BMS_MAP_SVH
`define BMS_ADDR_PRESET1 8'h10
`define BMS_ADDR_PRESET2 8'h14
`define BMS_ADDR_PINFN 8'h18
`define BMS_ADDR_STATUS 8'h1c
`define BMS_ADDR_TARGET 8'h20
`define BMS_ADDR_CTRL 8'h24
`define BMS_FN_SCALE1 4'h5
`define BMS_FN_SCALE2 4'h6
`define BMS_PINFN_RST 16'h0000
`define BMS_PRESET_RST 28'h0000000
`define BMS_CTRL_RST 1'b1
`define BMS_CTRL_EN_BIT 0
`define BMS_ST_PWM_BIT 0
`define BMS_ST_TLIM_BIT 1
`define BMS_ST_SEL1_LSB 2
`define BMS_ST_SEL2_LSB 4
`define BMS_ST_LIGHT_BIT 6
`define BMS_TGT2_LSB 16
`define BMS_MCLK_KHZ 25000
`define BMS_FSW_KHZ 4000
`define BMS_TLIM_DIV 4
`define BMS_PWM_MIN_PULSES 32
`define BMS_MV_BASE 12'd600
`define BMS_MV_SPAN 19'd2200
`define BMS_CODE_FULL 19'd127
`endif

// file: design/bms_pkg.sv
// Types shared by the buck mode and voltage select block
package bms_pkg;
  typedef enum logic [5:0] {
    ST_ECO_IDLE = 6'b000001,
    ST_ECO_PULSE = 6'b000010,
    ST_PWM_HS = 6'b000100,
    ST_PWM_LS = 6'b001000,
    ST_TLIM_HS = 6'b010000,
    ST_TLIM_OFF = 6'b100000
  } bms_state_t;

  typedef struct packed {
    logic pwm_trip;
    logic ilim_trip;
    logic vout_short;
    logic load_high;
    logic eco_trip;
    logic peak_ilim;
  } bms_sense_t;

  typedef struct packed {
    logic hs_on;
    logic ls_on;
  } bms_drive_t;
endpackage

// file: design/bms_sync.sv
// Two-stage synchroniser for asynchronous comparator and pin inputs
`timescale 1ns/100ps
`default_nettype none
module bms_sync #(
  parameter int W = 1
) (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      s1_q <= '0;
      s2_q <= '0;
    end else begin
      s1_q <= d;
      s2_q <= s1_q;
    end
  end

  assign q = s2_q;
endmodule
`default_nettype wire

// file: design/bms_preset_mem.sv
// Preset code memory: one word of four codes per regulator, registered reads
`timescale 1ns/100ps
`default_nettype none
`include "bms_map.svh"
module bms_preset_mem #(
  parameter int CW = 7,
  parameter int NP = 4,
  parameter int DEPTH = 2
) (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic we,
  input wire logic [$clog2(DEPTH)-1:0] waddr,
  input wire logic [CW*NP-1:0] wdata,
  input wire logic [$clog2(DEPTH)-1:0] raddr,
  output logic [CW*NP-1:0] rdata,
  input wire logic [2*DEPTH-1:0] sel,
  output logic [CW*DEPTH-1:0] code
);
  logic [CW*NP-1:0] mem_q [DEPTH];
  logic [CW*NP-1:0] mem_d [DEPTH];
  logic [CW*NP-1:0] rdata_q;
  logic [CW*DEPTH-1:0] code_q;
  logic [CW*DEPTH-1:0] code_d;

  always_comb begin
    for (int i = 0; i < DEPTH; i++) begin
      mem_d[i] = (we && waddr == i[$clog2(DEPTH)-1:0]) ? wdata : mem_q[i];
      code_d[i*CW +: CW] = mem_q[i][sel[i*2 +: 2]*CW +: CW];
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= `BMS_PRESET_RST;
      end
      rdata_q <= '0;
      code_q <= '0;
    end else begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= mem_d[i];
      end
      rdata_q <= mem_q[raddr];
      code_q <= code_d;
    end
  end

  assign rdata = rdata_q;
  assign code = code_q;
endmodule
`default_nettype wire

// file: design/bms_top.sv
// Buck switch sequencing, light-load mode control and pin-selected voltage presets
//
// Behaviour
// (RQ1) Modulation mode: high side on each cycle start, off on trip, then low side
// (RQ2) Current-limit comparator also ends the high-side on-time early
// (RQ3) Shorted output enters timed limit: quarter rate, low side disabled
// (RQ4) Modulation mode at heavier load, light-load burst mode below threshold
// (RQ5) Light-load: comparator fire gives one wide pulse, then idle until next fire
// (RQ6) Light-load leaves for modulation on load threshold or current limit
// (RQ7) Peak current sense in light-load starts modulation at next cycle start
// (RQ8) Latched peak current indication cleared at every cycle start
// (RQ9) Modulation held at least 32 pulses, then light-load only if load is light
// (RQ10) Target millivolts equal 600 plus code over 127 times 2200
// (RQ11) Software writes preset codes into the registers at 0x10 and 0x14
// (RQ12) No scaling uses preset 0, one bit presets 0-1, two bits 0-3
// (RQ13) Pin scaling only on regulators 1 and 2, four presets each
// (RQ14) Software assigns a pin to scaling with function code 0101 or 0110
// (RQ15) Single select pin: low picks preset 0, high picks preset 1
// (RQ16) Two-bit selection only on fixed pairs, first pin is upper bit
// (RQ17) Select pins are synchronised to the clock before use
// (RQ18) Processor holds select pins stable except on intended preset change
//
// The APB slave port and the address map were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "bms_map.svh"
module bms_top #(
  parameter int NPIN = 4,
  parameter int CW = 7,
  parameter int SW_DIV = `BMS_MCLK_KHZ / `BMS_FSW_KHZ,
  parameter int PWM_MIN = `BMS_PWM_MIN_PULSES
) (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire bms_pkg::bms_sense_t sense_raw,
  input wire logic [NPIN-1:0] mfp_in,
  output bms_pkg::bms_drive_t drive,
  output logic light_load_burst_mode,
  output logic [CW-1:0] vcode1,
  output logic [CW-1:0] vcode2,
  output logic [11:0] target_mv1,
  output logic [11:0] target_mv2
);
  import bms_pkg::*;

  localparam int DW = $clog2(SW_DIV);
  localparam int CNW = $clog2(PWM_MIN + 1);

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [2:0] pick_preset(input logic [4*NPIN-1:0] fn,
                                             input logic [NPIN-1:0] pins,
                                             input logic [3:0] code);
    logic [2:0] r;
    r = 3'b000;
    // Fixed pairs take precedence over a lone pin
    for (int p = NPIN / 2 - 1; p >= 0; p--) begin
      if (fn[8*p +: 4] == code && fn[8*p+4 +: 4] == code) begin
        r = {1'b1, pins[2*p], pins[2*p+1]}; // RQ16
      end
    end
    if (!r[2]) begin
      for (int p = NPIN - 1; p >= 0; p--) begin
        if (fn[4*p +: 4] == code) begin
          r = {1'b1, 1'b0, pins[p]}; // RQ15
        end
      end
    end
    return r;
  endfunction

  function automatic logic [11:0] code_to_mv(input logic [CW-1:0] c);
    logic [18:0] p;
    p = 19'(c) * `BMS_MV_SPAN;
    return `BMS_MV_BASE + 12'(p / `BMS_CODE_FULL); // RQ10
  endfunction

  function automatic logic addr_ok(input logic [7:0] a);
    return a == `BMS_ADDR_PRESET1 || a == `BMS_ADDR_PRESET2 || a == `BMS_ADDR_PINFN ||
           a == `BMS_ADDR_STATUS || a == `BMS_ADDR_TARGET || a == `BMS_ADDR_CTRL;
  endfunction

  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  bms_sense_t sense;
  logic [NPIN-1:0] pins;

  bms_sync #(.W($bits(bms_sense_t))) u_sense_sync (
    .mclk(mclk),
    .arst_n(arst_n),
    .d(sense_raw),
    .q(sense)
  );

  // Pin changes are asynchronous to the switching clock
  bms_sync #(.W(NPIN)) u_pin_sync ( // RQ17
    .mclk(mclk),
    .arst_n(arst_n),
    .d(mfp_in),
    .q(pins)
  );

  // ---------------------------------------------------------------
  // Register slave
  // ---------------------------------------------------------------
  logic [4*NPIN-1:0] pinfn_q, pinfn_d;
  logic en_q, en_d;
  logic [31:0] rdata_q, rdata_d;
  logic rdmem_q, rdmem_d;
  logic [4*CW-1:0] mem_rdata;
  logic [2*CW-1:0] mem_code;
  logic mem_we;
  logic [3:0] sel_q, sel_d;
  logic [11:0] mv1_q, mv1_d, mv2_q, mv2_d;
  bms_state_t st_q, st_d;
  logic setup, wr, is_preset;

  assign setup = psel && !penable;
  assign wr = psel && penable && pwrite;
  assign is_preset = paddr == `BMS_ADDR_PRESET1 || paddr == `BMS_ADDR_PRESET2;
  assign mem_we = wr && is_preset; // RQ11

  always_comb begin
    pinfn_d = pinfn_q;
    en_d = en_q;
    rdata_d = rdata_q;
    rdmem_d = rdmem_q;
    if (setup) begin
      rdmem_d = is_preset;
      rdata_d = '0;
      case (paddr)
        `BMS_ADDR_PINFN: rdata_d[4*NPIN-1:0] = pinfn_q;
        `BMS_ADDR_CTRL: rdata_d[`BMS_CTRL_EN_BIT] = en_q;
        `BMS_ADDR_STATUS: begin
          rdata_d[`BMS_ST_PWM_BIT] = st_q == ST_PWM_HS || st_q == ST_PWM_LS;
          rdata_d[`BMS_ST_TLIM_BIT] = st_q == ST_TLIM_HS || st_q == ST_TLIM_OFF;
          rdata_d[`BMS_ST_SEL1_LSB +: 2] = sel_q[1:0];
          rdata_d[`BMS_ST_SEL2_LSB +: 2] = sel_q[3:2];
          rdata_d[`BMS_ST_LIGHT_BIT] = light_load_burst_mode;
        end
        `BMS_ADDR_TARGET: begin
          rdata_d[11:0] = mv1_q;
          rdata_d[`BMS_TGT2_LSB +: 12] = mv2_q;
        end
        default: rdata_d = '0;
      endcase
    end
    if (wr && paddr == `BMS_ADDR_PINFN) begin
      pinfn_d = pwdata[4*NPIN-1:0]; // RQ14
    end
    if (wr && paddr == `BMS_ADDR_CTRL) begin
      en_d = pwdata[`BMS_CTRL_EN_BIT];
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      pinfn_q <= `BMS_PINFN_RST;
      en_q <= `BMS_CTRL_RST;
      rdata_q <= '0;
      rdmem_q <= 1'b0;
    end else begin
      pinfn_q <= pinfn_d;
      en_q <= en_d;
      rdata_q <= rdata_d;
      rdmem_q <= rdmem_d;
    end
  end

  // Zero wait states; preset reads come straight from the memory's read register
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_ok(paddr);
  assign prdata = rdmem_q ? {{(32 - 4 * CW){1'b0}}, mem_rdata} : rdata_q;

  // ---------------------------------------------------------------
  // Preset selection
  // ---------------------------------------------------------------
  bms_preset_mem #(.CW(CW), .NP(4), .DEPTH(2)) u_mem ( // RQ13
    .mclk(mclk),
    .arst_n(arst_n),
    .we(mem_we),
    .waddr(paddr == `BMS_ADDR_PRESET2),
    .wdata(pwdata[4*CW-1:0]),
    .raddr(paddr == `BMS_ADDR_PRESET2),
    .rdata(mem_rdata),
    .sel(sel_q),
    .code(mem_code)
  );

  logic [2:0] pk1, pk2;

  always_comb begin
    pk1 = pick_preset(pinfn_q, pins, `BMS_FN_SCALE1);
    pk2 = pick_preset(pinfn_q, pins, `BMS_FN_SCALE2);
    // No assigned pin leaves the regulator on preset 0
    sel_d = {pk2[2] ? pk2[1:0] : 2'b00, pk1[2] ? pk1[1:0] : 2'b00}; // RQ12
    mv1_d = code_to_mv(mem_code[CW-1:0]); // RQ10
    mv2_d = code_to_mv(mem_code[2*CW-1:CW]);
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      sel_q <= 4'h0;
      mv1_q <= `BMS_MV_BASE;
      mv2_q <= `BMS_MV_BASE;
    end else begin
      sel_q <= sel_d;
      mv1_q <= mv1_d;
      mv2_q <= mv2_d;
    end
  end

  assign vcode1 = mem_code[CW-1:0];
  assign vcode2 = mem_code[2*CW-1:CW];
  assign target_mv1 = mv1_q;
  assign target_mv2 = mv2_q;

  // ---------------------------------------------------------------
  // Switching clock dividers
  // ---------------------------------------------------------------
  logic [DW-1:0] div_q, div_d;
  logic [1:0] q4_q, q4_d;
  logic tick, tlim_tick;

  assign tick = div_q == DW'(SW_DIV - 1);
  assign tlim_tick = tick && q4_q == 2'(`BMS_TLIM_DIV - 1); // RQ3

  always_comb begin
    div_d = tick ? '0 : div_q + 1'b1;
    q4_d = tick ? q4_q + 1'b1 : q4_q;
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      div_q <= '0;
      q4_q <= 2'b00;
    end else begin
      div_q <= div_d;
      q4_q <= q4_d;
    end
  end

  // ---------------------------------------------------------------
  // Switch drive state machine
  // ---------------------------------------------------------------
  logic peak_q, peak_d;
  logic [CNW-1:0] cnt_q, cnt_d;
  bms_drive_t drv_q, drv_d;
  logic leave_pwm, cut_hs, to_pwm;

  assign leave_pwm = cnt_q >= CNW'(PWM_MIN) && !sense.load_high; // RQ9
  assign cut_hs = sense.pwm_trip || sense.ilim_trip; // RQ2
  assign to_pwm = sense.load_high || sense.ilim_trip; // RQ6

  always_comb begin
    // A new peak event in a tick cycle is kept, not lost
    peak_d = sense.peak_ilim || (peak_q && !tick); // RQ8
    st_d = st_q;
    cnt_d = (tick && cnt_q < CNW'(PWM_MIN)) ? cnt_q + 1'b1 : cnt_q;
    if (!en_q) begin
      st_d = ST_ECO_IDLE;
      cnt_d = '0;
    end else if (sense.vout_short && st_q != ST_TLIM_HS && st_q != ST_TLIM_OFF) begin
      st_d = ST_TLIM_OFF; // RQ3
    end else begin
      case (st_q)
        ST_ECO_IDLE, ST_ECO_PULSE: begin
          if (to_pwm) begin
            st_d = ST_PWM_HS; // RQ6
            cnt_d = '0;
          end else if (peak_q && tick) begin
            st_d = ST_PWM_HS; // RQ7
            cnt_d = '0;
          end else if (sense.eco_trip) begin
            st_d = ST_ECO_PULSE; // RQ5
          end else begin
            st_d = ST_ECO_IDLE; // RQ5
          end
        end
        ST_PWM_HS: begin
          if (tick) begin
            st_d = leave_pwm ? ST_ECO_IDLE : ST_PWM_HS; // RQ4
          end else if (cut_hs) begin
            st_d = ST_PWM_LS; // RQ1
          end
        end
        ST_PWM_LS: begin
          if (tick) begin
            st_d = leave_pwm ? ST_ECO_IDLE : ST_PWM_HS; // RQ1
          end
        end
        ST_TLIM_HS: begin
          if (!sense.vout_short) begin
            st_d = ST_PWM_HS;
            cnt_d = '0;
          end else if (cut_hs) begin
            st_d = ST_TLIM_OFF;
          end
        end
        ST_TLIM_OFF: begin
          if (!sense.vout_short) begin
            st_d = ST_PWM_HS;
            cnt_d = '0;
          end else if (tlim_tick) begin
            st_d = ST_TLIM_HS; // RQ3
          end
        end
        default: st_d = ST_ECO_IDLE;
      endcase
    end
    drv_d.hs_on = st_d == ST_PWM_HS || st_d == ST_ECO_PULSE || st_d == ST_TLIM_HS;
    // Low side only in modulation; timed limit leaves it off
    drv_d.ls_on = st_d == ST_PWM_LS; // RQ3
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= ST_ECO_IDLE;
      peak_q <= 1'b0;
      cnt_q <= '0;
      drv_q <= '0;
    end else begin
      st_q <= st_d;
      peak_q <= peak_d;
      cnt_q <= cnt_d;
      drv_q <= drv_d;
    end
  end

  assign drive = drv_q;
  assign light_load_burst_mode = st_q == ST_ECO_IDLE || st_q == ST_ECO_PULSE;
endmodule
`default_nettype wire

// file: bench/bms_assertions.sv
// Checker for switch drive, mode outputs and preset targets
`timescale 1ns/100ps
`default_nettype none
module bms_assertions
  import bms_pkg::*;
#(
  parameter int CW = 7
) (
  input wire logic mclk,
  input wire logic arst_n,
  input wire bms_pkg::bms_sense_t sense_raw,
  input wire bms_pkg::bms_drive_t drive,
  input wire logic light_load_burst_mode,
  input wire logic [CW-1:0] vcode1,
  input wire logic [CW-1:0] vcode2,
  input wire logic [11:0] target_mv1,
  input wire logic [11:0] target_mv2
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);
  // ----------
  // Properties
  // ----------
  // Repetition counts leave room for the two synchroniser stages
  a_drive_exclusive: assert property (!(drive.hs_on && drive.ls_on))
    else $error("both switches on");
  a_ls_after_hs: assert property ($rose(drive.ls_on) |-> $past(drive.hs_on))
    else $error("low side without high side first");
  a_short_no_ls: assert property (sense_raw.vout_short [*5] |-> !drive.ls_on)
    else $error("low side on in timed limit");
  a_load_leaves: assert property (sense_raw.load_high [*5] |-> !light_load_burst_mode)
    else $error("heavy load left in light mode");
  a_mod_hold: assert property ($fell(light_load_burst_mode) |-> !light_load_burst_mode [*8])
    else $error("modulation left too early");
  a_eco_idle: assert property (
    (!sense_raw.eco_trip) [*4] ##0 light_load_burst_mode |-> !drive.hs_on)
    else $error("switching in light mode without fire");
  a_eco_pulse: assert property (
    (sense_raw.eco_trip && !sense_raw.load_high) [*4] ##0 light_load_burst_mode |-> drive.hs_on)
    else $error("no wide pulse on fire");
  a_target_floor: assert property (vcode1 == 7'h00 |=> target_mv1 == 12'd600)
    else $error("code zero target wrong");
  a_target_full: assert property (vcode2 == 7'h7f |=> target_mv2 == 12'd2800)
    else $error("full code target wrong");
endmodule
bind bms_top bms_assertions #(.CW(CW)) u_bms_assertions (.mclk(mclk), .arst_n(arst_n),
  .sense_raw(sense_raw), .drive(drive), .light_load_burst_mode(light_load_burst_mode),
  .vcode1(vcode1), .vcode2(vcode2), .target_mv1(target_mv1), .target_mv2(target_mv2));
`default_nettype wire

// file: bench/bms_host_model.sv
// Baseband side model driving the voltage select pins
`timescale 1ns/100ps
`default_nettype none
module bms_host_model #(
  parameter int NPIN = 4
) (
  input wire logic mclk,
  input wire logic [NPIN-1:0] sel_req,
  output logic [NPIN-1:0] pins
);
  // ---------
  // Pin drive
  // ---------
  // All pins move in one step so a pair is never half updated by us
  always @(posedge mclk) begin
    if (pins !== sel_req) begin
      pins <= sel_req;
    end
  end
endmodule
`default_nettype wire

// file: bench/testbench.sv
// Self-checking bench for the buck mode and voltage select block
`timescale 1ns/100ps
`default_nettype none
`include "bms_map.svh"
module testbench;
  import bms_pkg::*;
  localparam int SWD = 6;
  localparam int PMIN = 4;
  localparam logic [4:0] S_ILIM = 5'h10;
  localparam logic [4:0] S_SHORT = 5'h08;
  localparam logic [4:0] S_LOAD = 5'h04;
  localparam logic [4:0] S_ECO = 5'h02;
  localparam logic [4:0] S_PEAK = 5'h01;
  logic mclk, arst_n, psel, penable, pwrite, pready, pslverr, llbm, trip_q, trip_en, er;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [4:0] sense_lo;
  logic [3:0] sel_req, mfp_in;
  logic [6:0] vcode1, vcode2;
  logic [11:0] tmv1, tmv2;
  logic [6:0] tab [4];
  bms_sense_t sense_raw;
  bms_drive_t drive;
  int err_total, n_tests, n, p;
  assign sense_raw = bms_sense_t'({trip_q, sense_lo});
  bms_top #(.SW_DIV(SWD), .PWM_MIN(PMIN)) u_bms_top (.mclk(mclk), .arst_n(arst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .sense_raw(sense_raw),
    .mfp_in(mfp_in), .drive(drive), .light_load_burst_mode(llbm), .vcode1(vcode1),
    .vcode2(vcode2), .target_mv1(tmv1), .target_mv2(tmv2));
  bms_host_model u_bms_host_model (.mclk(mclk), .sel_req(sel_req), .pins(mfp_in));
  // -----------------
  // Clock and helpers
  // -----------------
  always #20 mclk = ~mclk;
  // Modulation comparator trips one cycle after the high side closes
  always @(posedge mclk) trip_q <= drive.hs_on & trip_en;
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int k;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge mclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      err_total++;
      $display("unexpected at %0t: bus wait ran out", $time);
      give_verdict();
    end
  endtask
  // Waits on light mode (0), high side (1) or low side (2), at falling edges
  task automatic wait_sig(input int w, input logic lvl, output int c);
    logic v;
    c = 0;
    do begin
      @(negedge mclk);
      c++;
      v = (w == 0) ? llbm : (w == 1) ? drive.hs_on : drive.ls_on;
    end while (v !== lvl && c < 100);
    if (v !== lvl) begin
      err_total++;
      $display("unexpected at %0t: wait ran out", $time);
      give_verdict();
    end
  endtask
  task automatic period(output int q);
    int a;
    int b;
    wait_sig(1, 1'b0, a);
    wait_sig(1, 1'b1, a);
    wait_sig(1, 1'b0, a);
    wait_sig(1, 1'b1, b);
    q = a + b;
  endtask
  task automatic set_sense(input logic [4:0] v);
    @(posedge mclk);
    sense_lo <= v;
  endtask
  // --------
  // Sequence
  // --------
  initial begin
    mclk = 1'b0;
    arst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    sense_lo = '0;
    sel_req = '0;
    trip_en = 1'b1;
    err_total = 0;
    n_tests = 0;
    tab = '{7'h55, 7'h7f, 7'h00, 7'h2a};
    repeat (4) @(posedge mclk);
    arst_n <= 1'b1;
    @(negedge mclk);
    check(32'(llbm), 32'd1);
    check(32'(tmv1), 32'd600);
    apb(1'b1, `BMS_ADDR_PRESET1, {4'h0, tab[3], tab[2], tab[1], tab[0]});
    apb(1'b0, `BMS_ADDR_PRESET1, 32'h0);
    check(rd, {4'h0, tab[3], tab[2], tab[1], tab[0]});
    apb(1'b0, 8'h40, 32'h0);
    check({rd[30:0], er}, 32'h1);
    apb(1'b1, `BMS_ADDR_PRESET2, 32'h0000_007f);
    @(posedge mclk);
    sel_req <= 4'hf;
    repeat (8) @(negedge mclk);
    check(32'(vcode1), 32'(tab[0]));
    apb(1'b1, `BMS_ADDR_PINFN, {20'h0, `BMS_FN_SCALE2, `BMS_FN_SCALE1, `BMS_FN_SCALE1});
    for (int s = 0; s < 8; s++) begin
      @(posedge mclk);
      sel_req <= 4'(s);
      repeat (8) @(negedge mclk);
      check(32'(vcode1), 32'(tab[{s[0], s[1]}]));
      check(32'(vcode2), s[2] ? 32'h0 : 32'h7f);
      check(32'(tmv2), s[2] ? 32'd600 : 32'd2800);
    end
    // Pins 0111: pair gives preset 3, lone pin preset 1, still light load
    apb(1'b0, `BMS_ADDR_STATUS, 32'h0);
    check(rd, 32'h0000_005c);
    apb(1'b0, `BMS_ADDR_TARGET, 32'h0);
    check(rd, {4'h0, 12'd600, 4'h0, 12'd1327});
    set_sense(S_ECO);
    wait_sig(1, 1'b1, n);
    check(32'(llbm), 32'd1);
    set_sense('0);
    wait_sig(1, 1'b0, n);
    repeat (20) @(negedge mclk);
    check(32'(drive), 32'd0);
    set_sense(S_PEAK);
    set_sense('0);
    wait_sig(0, 1'b0, n);
    check(32'(n <= SWD + 4), 32'd1);
    wait_sig(0, 1'b1, n);
    check(32'(n >= (PMIN - 1) * SWD), 32'd1);
    repeat (3 * SWD) @(negedge mclk);
    check(32'(llbm), 32'd1);
    set_sense(S_LOAD);
    wait_sig(0, 1'b0, n);
    check(32'(n <= 5), 32'd1);
    period(p);
    check(32'(p), SWD);
    repeat (60) @(negedge mclk);
    check(32'(llbm), 32'd0);
    set_sense('0);
    wait_sig(0, 1'b1, n);
    trip_en <= 1'b0;
    set_sense(S_ILIM);
    wait_sig(0, 1'b0, n);
    check(32'(n <= 5), 32'd1);
    wait_sig(1, 1'b1, n);
    wait_sig(1, 1'b0, n);
    check(32'(n < SWD), 32'd1);
    trip_en <= 1'b1;
    set_sense(S_SHORT);
    period(p);
    period(p);
    check(32'(p), 4 * SWD);
    check(32'(llbm), 32'd0);
    apb(1'b0, `BMS_ADDR_CTRL, 32'h0);
    check(rd, 32'h1);
    apb(1'b1, `BMS_ADDR_CTRL, 32'h0);
    repeat (2) @(negedge mclk);
    check(32'({llbm, drive}), 32'h4);
    give_verdict();
  end
endmodule
`default_nettype wire
